// *** logic/ctrb_fuse_rom.sv ***
// ctrb_fuse_rom: calibration fuse image, one 16-bit word per trim register
// assumes: image is fixed at build time; read data registered, one cycle latency
`timescale 1ns/1ns
`include "ctrb_params.svh"

module ctrb_fuse_rom #(
  parameter int WORDS = 9,
  parameter int AW = 4,
  parameter int DW = 16,
  parameter logic [WORDS*DW-1:0] IMAGE = '0
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      rd_data <= '0;
    end
    else if (int'(rd_addr) < WORDS)
    begin
      rd_data <= IMAGE[int'(rd_addr)*DW +: DW];
    end
    else
    begin
      rd_data <= '0;
    end
  end

endmodule : ctrb_fuse_rom

// *** logic/ctrb_params.svh ***
// ctrb_params.svh: register indices, field positions and reset values of the trim bank
// assumes: included by bare name by the package users and the design modules
`ifndef CTRB_PARAMS_SVH
`define CTRB_PARAMS_SVH

// register indices; byte address on the bus is four times the index
`define CTRB_IDX_CORE4_OFFSET 12'h33C
`define CTRB_IDX_CORE5_OFFSET 12'h33E
`define CTRB_IDX_CORE0_GAIN 12'h360
`define CTRB_IDX_CORE1_GAIN 12'h361
`define CTRB_IDX_CORE2_PAIR_A_GAIN 12'h362
`define CTRB_IDX_CORE2_PAIR_B_GAIN 12'h363
`define CTRB_IDX_CORE3_PAIR_C_GAIN 12'h364
`define CTRB_IDX_CORE3_PAIR_D_GAIN 12'h365
`define CTRB_IDX_CORE4_GAIN 12'h366

// storage slots, also the fuse word order
`define CTRB_SLOT_CORE4_OFFSET 4'h0
`define CTRB_SLOT_CORE5_OFFSET 4'h1
`define CTRB_SLOT_CORE0_GAIN 4'h2
`define CTRB_SLOT_CORE1_GAIN 4'h3
`define CTRB_SLOT_CORE2_A_GAIN 4'h4
`define CTRB_SLOT_CORE2_B_GAIN 4'h5
`define CTRB_SLOT_CORE3_C_GAIN 4'h6
`define CTRB_SLOT_CORE3_D_GAIN 4'h7
`define CTRB_SLOT_CORE4_GAIN 4'h8
`define CTRB_SLOT_LAST 4'h8

// field layout
`define CTRB_OFFSET_MSB 11
`define CTRB_OFFSET_REG_MSB 15
`define CTRB_GAIN_MSB 4
`define CTRB_GAIN_REG_MSB 7

// nominal register reset value, replaced by fuse data after the load
`define CTRB_REG_RESET 16'h0000
`define CTRB_RDATA_ZERO 32'h0000_0000
`define CTRB_LOAD_MAX_CYCLES 20

`endif

// *** logic/ctrb_pkg.sv ***
// ctrb_pkg: types shared by the trim bank modules
// assumes: no other package
package ctrb_pkg;

  typedef enum logic [1:0]
  {
    CTRB_ST_FETCH = 2'b00,
    CTRB_ST_STORE = 2'b01,
    CTRB_ST_RUN = 2'b10
  } ctrb_load_state_t;

  typedef logic [3:0] ctrb_slot_t;
  typedef logic [15:0] ctrb_word_t;

endpackage : ctrb_pkg

// *** logic/ctrb_trim_bank.sv ***
// ctrb_trim_bank: per-core offset and fine gain trims behind an apb slave
// assumes: apb master in the core_clk domain; pair selects are synchronous levels
`timescale 1ns/1ns
`include "ctrb_params.svh"

module ctrb_trim_bank #(
  parameter int ADDR_W = 12,
  parameter int SLOTS = 9,
  parameter logic [SLOTS*16-1:0] FUSE_IMAGE = '0
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic core2_input_pair_b,
  input wire logic core3_input_pair_d,
  output logic trim_loaded,
  output logic [`CTRB_OFFSET_MSB:0] core4_offset_adj,
  output logic [`CTRB_OFFSET_MSB:0] core5_offset_adj,
  output logic [`CTRB_GAIN_MSB:0] core0_gain_adj,
  output logic [`CTRB_GAIN_MSB:0] core1_gain_adj,
  output logic [`CTRB_GAIN_MSB:0] core2_gain_adj,
  output logic [`CTRB_GAIN_MSB:0] core3_gain_adj,
  output logic [`CTRB_GAIN_MSB:0] core4_gain_adj
);

  ctrb_pkg::ctrb_word_t trim [SLOTS];
  ctrb_pkg::ctrb_load_state_t load_state;
  ctrb_pkg::ctrb_slot_t load_slot;
  ctrb_pkg::ctrb_word_t fuse_word;
  logic access_cycle;
  logic wr_commit;
  logic [4:0] cur_decode;

  // returns {hit, slot}; unaligned or unmapped addresses give hit low
  function automatic logic [4:0] decode_slot(input logic [ADDR_W-1:0] addr);
    logic [9:0] idx;
    logic [4:0] res;
    idx = addr[11:2];
    res = {1'b0, `CTRB_SLOT_CORE4_OFFSET};
    if (addr[1:0] != 2'h0)
    begin
      res = {1'b0, `CTRB_SLOT_CORE4_OFFSET};
    end
    else if (idx == `CTRB_IDX_CORE4_OFFSET)
    begin
      res = {1'b1, `CTRB_SLOT_CORE4_OFFSET};
    end
    else if (idx == `CTRB_IDX_CORE5_OFFSET)
    begin
      res = {1'b1, `CTRB_SLOT_CORE5_OFFSET};
    end
    else if (idx == `CTRB_IDX_CORE0_GAIN)
    begin
      res = {1'b1, `CTRB_SLOT_CORE0_GAIN};
    end
    else if (idx == `CTRB_IDX_CORE1_GAIN)
    begin
      res = {1'b1, `CTRB_SLOT_CORE1_GAIN};
    end
    else if (idx == `CTRB_IDX_CORE2_PAIR_A_GAIN)
    begin
      res = {1'b1, `CTRB_SLOT_CORE2_A_GAIN};
    end
    else if (idx == `CTRB_IDX_CORE2_PAIR_B_GAIN)
    begin
      res = {1'b1, `CTRB_SLOT_CORE2_B_GAIN};
    end
    else if (idx == `CTRB_IDX_CORE3_PAIR_C_GAIN)
    begin
      res = {1'b1, `CTRB_SLOT_CORE3_C_GAIN};
    end
    else if (idx == `CTRB_IDX_CORE3_PAIR_D_GAIN)
    begin
      res = {1'b1, `CTRB_SLOT_CORE3_D_GAIN};
    end
    else if (idx == `CTRB_IDX_CORE4_GAIN)
    begin
      res = {1'b1, `CTRB_SLOT_CORE4_GAIN};
    end
    return res;
  endfunction : decode_slot

  // gain registers are one byte wide, offset registers two
  function automatic ctrb_pkg::ctrb_word_t reg_width_mask(input ctrb_pkg::ctrb_slot_t slot);
    ctrb_pkg::ctrb_word_t m;
    m = 16'hFFFF;
    if (slot >= `CTRB_SLOT_CORE0_GAIN)
    begin
      m = 16'h00FF;
    end
    return m;
  endfunction : reg_width_mask

  ctrb_fuse_rom #(
    .WORDS(SLOTS),
    .AW(4),
    .DW(16),
    .IMAGE(FUSE_IMAGE)
  ) u_fuse (
    .core_clk(core_clk),
    .reset(reset),
    .rd_addr(load_slot),
    .rd_data(fuse_word)
  );

  assign cur_decode = decode_slot(paddr);
  // answer is held off until the fuse defaults are in place
  assign access_cycle = psel & penable & ~pready & trim_loaded;
  assign wr_commit = psel & penable & pready & pwrite & cur_decode[4];

  // fuse load sequencer: two cycles per word, then run
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      load_state <= ctrb_pkg::CTRB_ST_FETCH;
      load_slot <= `CTRB_SLOT_CORE4_OFFSET;
      trim_loaded <= 1'b0;
    end
    else
    begin
      case (load_state)
        ctrb_pkg::CTRB_ST_FETCH:
        begin
          load_state <= ctrb_pkg::CTRB_ST_STORE;
        end
        ctrb_pkg::CTRB_ST_STORE:
        begin
          if (load_slot == `CTRB_SLOT_LAST)
          begin
            load_state <= ctrb_pkg::CTRB_ST_RUN;
            trim_loaded <= 1'b1;
          end
          else
          begin
            load_slot <= load_slot + 4'h1;
            load_state <= ctrb_pkg::CTRB_ST_FETCH;
          end
        end
        default:
        begin
          load_state <= ctrb_pkg::CTRB_ST_RUN;
        end
      endcase
    end
  end

  // trim storage: nominal zero at reset, fuse word during load, bus writes after
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < SLOTS; i++)
      begin
        trim[i] <= `CTRB_REG_RESET;
      end
    end
    else if (load_state == ctrb_pkg::CTRB_ST_STORE)
    begin
      trim[load_slot] <= fuse_word & reg_width_mask(load_slot);
    end
    else if (wr_commit)
    begin
      // reserved bits are kept as written; software keeps them zero
      trim[cur_decode[3:0]] <= pwdata[15:0] & reg_width_mask(cur_decode[3:0]);
    end
  end

  // apb answer: one wait state, then pready with data and error together
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `CTRB_RDATA_ZERO;
    end
    else
    begin
      pready <= access_cycle;
      pslverr <= access_cycle & ~cur_decode[4];
      if (access_cycle & ~pwrite & cur_decode[4])
      begin
        prdata <= {16'h0000, trim[cur_decode[3:0]]};
      end
      else
      begin
        prdata <= `CTRB_RDATA_ZERO;
      end
    end
  end

  // offset fields to the datapath
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      core4_offset_adj <= '0;
      core5_offset_adj <= '0;
    end
    else
    begin
      core4_offset_adj <= trim[`CTRB_SLOT_CORE4_OFFSET][`CTRB_OFFSET_MSB:0];
      core5_offset_adj <= trim[`CTRB_SLOT_CORE5_OFFSET][`CTRB_OFFSET_MSB:0];
    end
  end

  // gain fields; split cores follow their input pair select cycle by cycle
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      core0_gain_adj <= '0;
      core1_gain_adj <= '0;
      core2_gain_adj <= '0;
      core3_gain_adj <= '0;
      core4_gain_adj <= '0;
    end
    else
    begin
      core0_gain_adj <= trim[`CTRB_SLOT_CORE0_GAIN][`CTRB_GAIN_MSB:0];
      core1_gain_adj <= trim[`CTRB_SLOT_CORE1_GAIN][`CTRB_GAIN_MSB:0];
      core4_gain_adj <= trim[`CTRB_SLOT_CORE4_GAIN][`CTRB_GAIN_MSB:0];
      if (core2_input_pair_b)
      begin
        core2_gain_adj <= trim[`CTRB_SLOT_CORE2_B_GAIN][`CTRB_GAIN_MSB:0];
      end
      else
      begin
        core2_gain_adj <= trim[`CTRB_SLOT_CORE2_A_GAIN][`CTRB_GAIN_MSB:0];
      end
      if (core3_input_pair_d)
      begin
        core3_gain_adj <= trim[`CTRB_SLOT_CORE3_D_GAIN][`CTRB_GAIN_MSB:0];
      end
      else
      begin
        core3_gain_adj <= trim[`CTRB_SLOT_CORE3_C_GAIN][`CTRB_GAIN_MSB:0];
      end
    end
  end

  // checks
  default clocking chk_cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // bound leaves two cycles of slack: the load itself needs two cycles per slot
  localparam int LOAD_MAX = `CTRB_LOAD_MAX_CYCLES;

  logic [ADDR_W-1:0] addr_core4_ofs;
  logic [ADDR_W-1:0] addr_core5_ofs;
  logic [ADDR_W-1:0] addr_core0_gain;
  logic [ADDR_W-1:0] addr_core4_gain;
  assign addr_core4_ofs = {10'(`CTRB_IDX_CORE4_OFFSET), 2'h0};
  assign addr_core5_ofs = {10'(`CTRB_IDX_CORE5_OFFSET), 2'h0};
  assign addr_core0_gain = {10'(`CTRB_IDX_CORE0_GAIN), 2'h0};
  assign addr_core4_gain = {10'(`CTRB_IDX_CORE4_GAIN), 2'h0};

  chk_offset_field_apply: assert property (
    psel && penable && pready && pwrite && paddr == addr_core4_ofs
    |=> ##1 core4_offset_adj == $past(pwdata[11:0], 2))
    else $error("core 4 offset trim not applied from bits 11:0");

  chk_gain_field_apply: assert property (
    psel && penable && pready && pwrite && paddr == addr_core0_gain
    |=> ##1 core0_gain_adj == $past(pwdata[4:0], 2))
    else $error("core 0 gain trim not applied from bits 4:0");

  chk_core5_ofs_apply: assert property (
    psel && penable && pready && pwrite && paddr == addr_core5_ofs
    |=> ##1 core5_offset_adj == $past(pwdata[11:0], 2))
    else $error("core 5 offset trim not applied from bits 11:0");

  chk_gain_read_width: assert property (
    psel && penable && !pready && trim_loaded && !pwrite && paddr == addr_core4_gain
    |=> pready && prdata[31:8] == 24'h000000)
    else $error("gain register reads wider than one byte");

  chk_fuse_load_done: assert property (
    !trim_loaded |-> ##[1:LOAD_MAX] trim_loaded)
    else $error("fuse defaults not loaded in time");

  chk_fuse_blocks_bus: assert property (
    !trim_loaded |-> !pready && !pslverr && prdata == `CTRB_RDATA_ZERO)
    else $error("bus answered before fuse load");

  chk_core2_pair_sel: assert property (
    trim_loaded |=> core2_gain_adj == ($past(core2_input_pair_b)
      ? $past(trim[`CTRB_SLOT_CORE2_B_GAIN][4:0])
      : $past(trim[`CTRB_SLOT_CORE2_A_GAIN][4:0])))
    else $error("core 2 gain does not follow its input pair");

  chk_core3_pair_sel: assert property (
    trim_loaded |=> core3_gain_adj == ($past(core3_input_pair_d)
      ? $past(trim[`CTRB_SLOT_CORE3_D_GAIN][4:0])
      : $past(trim[`CTRB_SLOT_CORE3_C_GAIN][4:0])))
    else $error("core 3 gain does not follow its input pair");

  chk_gain_map_read: assert property (
    psel && penable && !pready && trim_loaded && !pwrite && paddr == addr_core0_gain
    |=> pready && !pslverr
      && prdata == {16'h0000, $past(trim[`CTRB_SLOT_CORE0_GAIN])})
    else $error("core 0 gain not at its index");

  chk_core5_ofs_map: assert property (
    psel && penable && !pready && trim_loaded && !pwrite && paddr == addr_core5_ofs
    |=> pready && !pslverr
      && prdata == {16'h0000, $past(trim[`CTRB_SLOT_CORE5_OFFSET])})
    else $error("core 5 offset not at its own index");

  chk_gap_index_err: assert property (
    psel && penable && !pready && trim_loaded && paddr == addr_core4_ofs + 12'h004
    |=> pready && pslverr ##1 !pready)
    else $error("index between offset registers answered without error");

  // a refused write must leave both stored offset trims untouched
  chk_err_write_ignored: assert property (
    psel && penable && pready && pwrite && pslverr && trim_loaded
    |=> $stable(trim[`CTRB_SLOT_CORE4_OFFSET]) && $stable(trim[`CTRB_SLOT_CORE5_OFFSET]))
    else $error("refused write changed an offset trim");

  chk_unaligned_err: assert property (
    psel && penable && !pready && trim_loaded && paddr[1:0] != 2'h0
    |=> pready && pslverr && prdata == `CTRB_RDATA_ZERO)
    else $error("unaligned access answered without error");

endmodule : ctrb_trim_bank

// *** sim/ctrb_tb.sv ***
// tb: self-checking bench for the trim bank, apb master plus a register model
// assumes: design files compiled first; ctrb_params.svh on the include path
`timescale 1ns/1ns
`include "ctrb_params.svh"

module tb;
  // reserved bits set in two fuse words: gains keep 8 bits, offsets 16
  localparam logic [143:0] FUSE = {16'h0019, 16'h0003, 16'h001E, 16'h000A, 16'h0015,
    16'h0007, 16'h1F11, 16'hF123, 16'h0ABC};
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pair_b = 1'b0;
  logic pair_d = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic trim_loaded;
  logic [11:0] core4_offset_trim;
  logic [11:0] core5_offset_trim;
  logic [4:0] g0;
  logic [4:0] g1;
  logic [4:0] g2;
  logic [4:0] g3;
  logic [4:0] g4;
  int fail_count = 0;
  int tests_run = 0;
  logic [15:0] lfsr_q = 16'hB1A8;
  logic [11:0] idx_tab [9] = '{`CTRB_IDX_CORE4_OFFSET, `CTRB_IDX_CORE5_OFFSET,
    `CTRB_IDX_CORE0_GAIN, `CTRB_IDX_CORE1_GAIN, `CTRB_IDX_CORE2_PAIR_A_GAIN,
    `CTRB_IDX_CORE2_PAIR_B_GAIN, `CTRB_IDX_CORE3_PAIR_C_GAIN,
    `CTRB_IDX_CORE3_PAIR_D_GAIN, `CTRB_IDX_CORE4_GAIN};
  logic [11:0] bad_tab [4] = '{12'hD81, 12'hD9C, 12'hCF4, 12'hCFC};
  int exp_reg [9];
  logic [31:0] rd;
  logic er;

  ctrb_trim_bank #(.ADDR_W(12), .SLOTS(9), .FUSE_IMAGE(FUSE)) u_dut (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core2_input_pair_b(pair_b),
    .core3_input_pair_d(pair_d), .trim_loaded(trim_loaded),
    .core4_offset_adj(core4_offset_trim), .core5_offset_adj(core5_offset_trim), .core0_gain_adj(g0),
    .core1_gain_adj(g1), .core2_gain_adj(g2), .core3_gain_adj(g3),
    .core4_gain_adj(g4)
  );

  initial
  begin
    forever #10 core_clk = ~core_clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // offsets keep 16 bits, gains 8
  function automatic int fmask(input int i);
    return (i < 2) ? 32'h0000_FFFF : 32'h0000_00FF;
  endfunction : fmask

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    tests_run++;
    if (seen !== expv)
    begin
      fail_count++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, expv);
    end
  endtask : chk

  task automatic give_verdict;
    if (fail_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // request held until pready is seen high at a rising edge; data and error
  // are taken at that edge and only then is the request dropped
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rdv, output logic erv);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic do_reset;
    int i;
    reset <= 1'b1;
    repeat (12) @(posedge core_clk);
    chk(32'(trim_loaded), 32'h0);
    for (i = 0; i < 9; i++)
      exp_reg[i] = FUSE[16*i +: 16] & fmask(i);
    reset <= 1'b0;
  endtask : do_reset

  task automatic chk_out;
    @(negedge core_clk);
    chk(32'(core4_offset_trim), exp_reg[0] & 12'hFFF);
    chk(32'(core5_offset_trim), exp_reg[1] & 12'hFFF);
    chk(32'(g0), exp_reg[2] & 5'h1F);
    chk(32'(g1), exp_reg[3] & 5'h1F);
    chk(32'(g2), exp_reg[pair_b ? 5 : 4] & 5'h1F);
    chk(32'(g3), exp_reg[pair_d ? 7 : 6] & 5'h1F);
    chk(32'(g4), exp_reg[8] & 5'h1F);
  endtask : chk_out

  task automatic check_all;
    int i;
    for (i = 0; i < 9; i++)
    begin
      apb(1'b0, 12'(idx_tab[i] * 4), 32'h0, rd, er);
      chk(rd, exp_reg[i]);
      chk(32'(er), 32'h0);
    end
    chk(32'(trim_loaded), 32'h1);
    chk_out;
  endtask : check_all

  initial
  begin
    int i;
    int k;
    logic [31:0] d;
    // first read is issued while the fuse load runs and must simply wait
    do_reset;
    check_all;
    for (i = 0; i < 9; i++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      // reserved upper bits written as zero
      d = {16'h0000, lfsr_q} & ((i < 2) ? 32'h0000_0FFF : 32'h0000_001F);
      apb(1'b1, 12'(idx_tab[i] * 4), d, rd, er);
      chk(32'(er), 32'h0);
      exp_reg[i] = d;
    end
    check_all;
    for (k = 0; k < 4; k++)
    begin
      @(posedge core_clk);
      pair_b <= k[0];
      pair_d <= k[1];
      repeat (2) @(posedge core_clk);
      chk_out;
    end
    // holes and unaligned words: refused, and no register may change
    for (i = 0; i < 4; i++)
    begin
      apb(1'b1, bad_tab[i], 32'h0000_001F, rd, er);
      chk(32'(er), 32'h1);
      apb(1'b0, bad_tab[i], 32'h0, rd, er);
      chk(32'(er), 32'h1);
      chk(rd, 32'h0);
    end
    check_all;
    // second reset brings the fuse defaults back over the written values
    @(posedge core_clk);
    do_reset;
    check_all;
    give_verdict;
  end

  initial
  begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    give_verdict;
  end
endmodule : tb
